/* File: verilog/cpu_if_pkg.sv */
// How it works
// - Priority mask shared by both views
// - Group 0 active priority shared storage
// - Non-secure active priority shares group 1 copy
// - Common binary point bit steers binary point
// - Sharing mode change makes contents unknown, except the binary points
// - Same priority bits and minimum binary point
// - Enable bits block memory-mapped register sets
// - Virtual memory-mapped set still provided; only the physical set takes writes
// - Forbidden memory-mapped accesses are flagged
// - Priority mask write takes effect alone
// - Acknowledge reads self-synchronise when masked
// - Exception return applies interrupt reassignment together
// - Barrier publishes mask when hint enabled
// - Barrier publishes last generate register writes
// - Barrier publishes latest group enable values
// - Barrier publishes last shared acknowledged identifier
// - Barrier publishes last private acknowledged identifier
// - Barrier publishes last direct-injected virtual identifier
// - Barrier publishes shared deactivate commands
// - Barrier publishes private deactivate commands
// - Read-only ignores writes, write-only reads unknown
package cpu_if_pkg;
  localparam int PRIO_BITS = 8;
  localparam int AP_WORDS  = 4;
  localparam int BP_BITS   = 3;
  localparam int ID_BITS   = 24;

  // Register indices within each view (byte address = 4 * index)
  localparam logic [7:0] REG_PRIORITY_MASK  = 8'h00;
  localparam logic [7:0] REG_BINARY_POINT   = 8'h01;
  localparam logic [7:0] REG_ALIAS_BP       = 8'h02;
  localparam logic [7:0] REG_CONTROL        = 8'h03;
  localparam logic [7:0] REG_SGI_GENERATE   = 8'h04;
  localparam logic [7:0] REG_STATUS         = 8'h05;
  localparam logic [7:0] REG_GROUP0_AP_BASE = 8'h10;
  localparam logic [7:0] REG_NS_AP_BASE     = 8'h20;

  // Control register fields
  localparam int CTL_COMMON_BINARY_POINT_CONTROL   = 0;
  localparam int CTL_PRIORITY_HINT_ENABLE   = 1;
  localparam int CTL_EN_G0  = 2;
  localparam int CTL_EN_G1  = 3;
  localparam int CTL_VEN_G0 = 4;
  localparam int CTL_VEN_G1 = 5;

  localparam logic [BP_BITS-1:0]   BP_G0_MIN  = 3'h2;
  localparam logic [PRIO_BITS-1:0] PRIO_RESET = 8'h00;

  typedef enum logic [1:0] {
    VIEW_PHYS,
    VIEW_HYP,
    VIEW_VIRT
  } mmio_view_t;

  typedef struct packed {
    logic [PRIO_BITS-1:0] priority_mask;
    logic                 priority_hint_enable;
    logic                 group0_enable;
    logic                 group1_enable;
    logic                 vgroup0_enable;
    logic                 vgroup1_enable;
    logic [31:0]          sgi_generate;
    logic [ID_BITS-1:0]   spi_ack_id;
    logic [ID_BITS-1:0]   local_ack_id;
    logic [ID_BITS-1:0]   virtual_locality_interrupt_ack_id;
    logic [ID_BITS-1:0]   spi_deactivate_id;
    logic [ID_BITS-1:0]   local_deactivate_id;
  } publish_t;

  typedef struct packed {
    logic                 wr;
    logic [7:0]           index;
    logic [31:0]          data;
  } sysreg_req_t;
endpackage

/* File: verilog/shared_reg.sv */
`timescale 1ns/1ps
// One storage cell with two write ports; sysreg port wins on a collision
module shared_reg #(
  parameter int          W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Scramble on sharing mode change
  input  wire logic         scramble,
  // Ports
  input  wire logic         we_a,
  input  wire logic [W-1:0] wd_a,
  input  wire logic         we_b,
  input  wire logic [W-1:0] wd_b,
  output logic      [W-1:0] q
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST;
    end else if (scramble) begin
      q <= ~q;
    end else if (we_a) begin
      q <= wd_a;
    end else if (we_b) begin
      q <= wd_b;
    end
  end
endmodule

/* File: verilog/cpu_if_coherency.sv */
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cpu_if_coherency (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // APB memory-mapped view
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // System register view
  input  wire cpu_if_pkg::sysreg_req_t sys_req,
  input  wire logic                 sys_valid,
  output logic      [31:0]          sys_rdata,
  // Access enables and core state
  input  wire logic                 sre_secure,
  input  wire logic                 sre_hyp,
  input  wire logic                 sre_nonsecure,
  input  wire logic                 secure_access,
  input  wire logic                 fiq_mask_bit,
  input  wire logic                 irq_mask_bit,
  input  wire logic                 exception_return,
  input  wire logic                 group0_is_fiq_next,
  // Interrupt acknowledge and deactivate events
  input  wire logic                 ack_valid,
  input  wire logic                 ack_is_spi,
  input  wire logic                 ack_is_virtual_locality_interrupt_direct,
  input  wire logic [cpu_if_pkg::ID_BITS-1:0] ack_id,
  input  wire logic                 ack_read_group1,
  input  wire logic                 deact_valid,
  input  wire logic                 deact_is_spi,
  input  wire logic [cpu_if_pkg::ID_BITS-1:0] deact_id,
  // Barrier
  input  wire logic                 data_sync_barrier,
  // Outputs to core and distributor side
  output logic [cpu_if_pkg::PRIO_BITS-1:0] effective_priority_mask,
  output logic                      ack_sync_done,
  output logic                      group0_is_fiq,
  output logic                      forbidden_access,
  output cpu_if_pkg::publish_t      published
);
  localparam int PB = cpu_if_pkg::PRIO_BITS;
  localparam int BB = cpu_if_pkg::BP_BITS;

  // APB decode
  logic       setup;
  logic       access;
  logic [7:0] apb_idx;
  // View select: 0 physical, 1 hypervisor, 2 virtual
  logic [1:0] apb_view;
  logic       view_blocked;
  logic       apb_we;

  assign access  = psel && penable && pready;
  assign setup   = psel && !penable;
  assign apb_idx = paddr[9:2];
  assign apb_view = paddr[11:10];

  always_comb begin
    case (apb_view)
      2'h0:    view_blocked = sre_secure;
      2'h1:    view_blocked = sre_hyp;
      2'h2:    view_blocked = sre_nonsecure;
      default: view_blocked = 1'b1;
    endcase
  end

  // Blocked sets are read-as-zero, write-ignored
  assign apb_we = access && pwrite && !view_blocked && apb_view == 2'h0;

  logic sys_we;
  assign sys_we = sys_valid && sys_req.wr;

  // Sharing required while secure enable is programmable-and-clear; change scrambles
  logic share_q;
  logic scramble;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      share_q <= 1'b1;
    end else begin
      share_q <= !sre_secure;
    end
  end
  assign scramble = share_q != !sre_secure;

  // Priority mask
  logic [PB-1:0] pmr;
  shared_reg #(.W(PB), .RST(cpu_if_pkg::PRIO_RESET)) u_pmr (
    .clk      (clk),
    .rst_n    (rst_n),
    .scramble (scramble),
    .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_PRIORITY_MASK),
    .wd_a     (sys_req.data[PB-1:0]),
    .we_b     (apb_we && apb_idx == cpu_if_pkg::REG_PRIORITY_MASK),
    .wd_b     (pwdata[PB-1:0]),
    .q        (pmr)
  );

  // Active priority words: group 0 and non-secure/group 1
  logic [31:0] ap0 [cpu_if_pkg::AP_WORDS];
  logic [31:0] ap1 [cpu_if_pkg::AP_WORDS];
  for (genvar n = 0; n < cpu_if_pkg::AP_WORDS; n++) begin : g_ap
    shared_reg #(.W(32)) u_ap0 (
      .clk      (clk),
      .rst_n    (rst_n),
      .scramble (scramble),
      .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_GROUP0_AP_BASE + 8'(n)),
      .wd_a     (sys_req.data),
      .we_b     (apb_we && apb_idx == cpu_if_pkg::REG_GROUP0_AP_BASE + 8'(n)),
      .wd_b     (pwdata),
      .q        (ap0[n])
    );
    shared_reg #(.W(32)) u_ap1 (
      .clk      (clk),
      .rst_n    (rst_n),
      .scramble (scramble),
      .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_NS_AP_BASE + 8'(n)),
      .wd_a     (sys_req.data),
      .we_b     (apb_we && apb_idx == cpu_if_pkg::REG_NS_AP_BASE + 8'(n)),
      .wd_b     (pwdata),
      .q        (ap1[n])
    );
  end

  // Control word (common binary point, hint enable, group enables)
  logic [5:0] ctl;
  shared_reg #(.W(6)) u_ctl (
    .clk      (clk),
    .rst_n    (rst_n),
    .scramble (scramble),
    .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_CONTROL),
    .wd_a     (sys_req.data[5:0]),
    .we_b     (apb_we && apb_idx == cpu_if_pkg::REG_CONTROL),
    .wd_b     (pwdata[5:0]),
    .q        (ctl)
  );

  // Binary points: secure MMIO accesses hit sysreg state while common bit is 0
  logic [BB-1:0] bp0;
  logic [BB-1:0] bp1;
  logic          mmio_bp_shared;
  assign mmio_bp_shared = secure_access && !ctl[cpu_if_pkg::CTL_COMMON_BINARY_POINT_CONTROL];

  function automatic logic [BB-1:0] clamp_bp0(input logic [BB-1:0] v);
    clamp_bp0 = (v < cpu_if_pkg::BP_G0_MIN) ? cpu_if_pkg::BP_G0_MIN : v;
  endfunction

  shared_reg #(.W(BB), .RST(cpu_if_pkg::BP_G0_MIN)) u_bp0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .scramble (1'b0),
    .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_BINARY_POINT),
    .wd_a     (clamp_bp0(sys_req.data[BB-1:0])),
    .we_b     (apb_we && mmio_bp_shared && apb_idx == cpu_if_pkg::REG_BINARY_POINT),
    .wd_b     (clamp_bp0(pwdata[BB-1:0])),
    .q        (bp0)
  );
  shared_reg #(.W(BB), .RST(cpu_if_pkg::BP_G0_MIN)) u_bp1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .scramble (1'b0),
    .we_a     (sys_we && sys_req.index == cpu_if_pkg::REG_ALIAS_BP),
    .wd_a     (sys_req.data[BB-1:0]),
    .we_b     (apb_we && mmio_bp_shared && apb_idx == cpu_if_pkg::REG_ALIAS_BP),
    .wd_b     (pwdata[BB-1:0]),
    .q        (bp1)
  );

  // SOFTWARE_GENERATED_INTERRUPT generate write latch, written from the system register view only
  logic [31:0] sgi_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sgi_q <= '0;
    end else if (sys_we && sys_req.index == cpu_if_pkg::REG_SGI_GENERATE) begin
      sgi_q <= sys_req.data;
    end
  end

  // Common read mux
  function automatic logic [31:0] read_reg(input logic [7:0] idx);
    read_reg = '0;
    if (idx == cpu_if_pkg::REG_PRIORITY_MASK) read_reg = 32'(pmr);
    if (idx == cpu_if_pkg::REG_BINARY_POINT) read_reg = 32'(bp0);
    if (idx == cpu_if_pkg::REG_ALIAS_BP) read_reg = 32'(bp1);
    if (idx == cpu_if_pkg::REG_CONTROL) read_reg = 32'(ctl);
    if (idx == cpu_if_pkg::REG_STATUS) read_reg = {30'h0, share_q, forbidden_access};
    // Write-only generate register reads an arbitrary value
    if (idx == cpu_if_pkg::REG_SGI_GENERATE) read_reg = 32'hDEAD_BEEF;
    for (int n = 0; n < cpu_if_pkg::AP_WORDS; n++) begin
      if (idx == cpu_if_pkg::REG_GROUP0_AP_BASE + 8'(n)) read_reg = ap0[n];
      if (idx == cpu_if_pkg::REG_NS_AP_BASE + 8'(n)) read_reg = ap1[n];
    end
  endfunction

  // APB slave: one wait state, answers in the second access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= view_blocked ? 32'h0000_0000 : read_reg(apb_idx);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_rdata <= '0;
    end else if (sys_valid && !sys_req.wr) begin
      sys_rdata <= read_reg(sys_req.index);
    end
  end

  // Sticky forbidden-access flag, cleared by a system register write of the status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      forbidden_access <= 1'b0;
    end else if (access && view_blocked) begin
      forbidden_access <= 1'b1;
    end else if (sys_we && sys_req.index == cpu_if_pkg::REG_STATUS) begin
      forbidden_access <= 1'b0;
    end
  end

  // Mask seen by the core follows the shared storage with no barrier needed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      effective_priority_mask <= cpu_if_pkg::PRIO_RESET;
    end else begin
      effective_priority_mask <= pmr;
    end
  end

  // Acknowledge read completes synchronised when the matching mask is set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_sync_done <= 1'b0;
    end else begin
      ack_sync_done <= ack_valid && (ack_read_group1 ? irq_mask_bit : fiq_mask_bit);
    end
  end

  // FIQ/IRQ assignment is loaded on the exception return and changes in the cycle after it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      group0_is_fiq <= 1'b1;
    end else if (exception_return) begin
      group0_is_fiq <= group0_is_fiq_next;
    end
  end

  // Pending values collected between barriers
  logic [cpu_if_pkg::ID_BITS-1:0] spi_ack_q, loc_ack_q, virtual_locality_interrupt_ack_q, spi_de_q, loc_de_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spi_ack_q  <= '0;
      loc_ack_q  <= '0;
      virtual_locality_interrupt_ack_q <= '0;
    end else if (ack_valid) begin
      if (ack_is_virtual_locality_interrupt_direct) begin
        virtual_locality_interrupt_ack_q <= ack_id;
      end else if (ack_is_spi) begin
        spi_ack_q <= ack_id;
      end else begin
        loc_ack_q <= ack_id;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spi_de_q <= '0;
      loc_de_q <= '0;
    end else if (deact_valid) begin
      if (deact_is_spi) begin
        spi_de_q <= deact_id;
      end else begin
        loc_de_q <= deact_id;
      end
    end
  end

  // Barrier publishes everything written before its own cycle, the mask only while hint is enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      published <= '0;
    end else if (data_sync_barrier) begin
      if (ctl[cpu_if_pkg::CTL_PRIORITY_HINT_ENABLE]) begin
        published.priority_mask <= pmr;
      end
      published.priority_hint_enable <= ctl[cpu_if_pkg::CTL_PRIORITY_HINT_ENABLE];
      published.sgi_generate         <= sgi_q;
      published.group0_enable        <= ctl[cpu_if_pkg::CTL_EN_G0];
      published.group1_enable        <= ctl[cpu_if_pkg::CTL_EN_G1];
      published.vgroup0_enable       <= ctl[cpu_if_pkg::CTL_VEN_G0];
      published.vgroup1_enable       <= ctl[cpu_if_pkg::CTL_VEN_G1];
      published.spi_ack_id           <= spi_ack_q;
      published.local_ack_id         <= loc_ack_q;
      published.virtual_locality_interrupt_ack_id          <= virtual_locality_interrupt_ack_q;
      published.spi_deactivate_id    <= spi_de_q;
      published.local_deactivate_id  <= loc_de_q;
    end
  end
endmodule

/* File: test/cpu_if_coherency_asserts.sv */
`timescale 1ns/1ps
module cpu_if_coherency_asserts (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // APB side
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     prdata,
  input  wire logic                            pready,
  // Core side
  input  wire cpu_if_pkg::sysreg_req_t         sys_req,
  input  wire logic                            sys_valid,
  input  wire logic [31:0]                     sys_rdata,
  input  wire logic                            sre_secure,
  input  wire logic                            exception_return,
  input  wire logic                            group0_is_fiq_next,
  input  wire logic                            data_sync_barrier,
  // Results
  input  wire logic [cpu_if_pkg::PRIO_BITS-1:0] effective_priority_mask,
  input  wire logic                            group0_is_fiq,
  input  wire logic                            forbidden_access,
  input  wire cpu_if_pkg::publish_t            published
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  sequence phys_done_s;
    psel && penable && pready && paddr[11:10] == 2'h0 && sre_secure;
  endsequence
  apb_wait_state_a: assert property (setup_s |=> access_s)
    else $error("apb answer timing off");
  mask_write_a: assert property (
    sys_valid && sys_req.wr && sys_req.index == cpu_if_pkg::REG_PRIORITY_MASK
    |-> ##2 effective_priority_mask == $past(sys_req.data[7:0], 2))
    else $error("mask write lost");
  sysreg_read_a: assert property (
    sys_valid && !sys_req.wr && sys_req.index == cpu_if_pkg::REG_PRIORITY_MASK
    |=> sys_rdata == 32'($past(effective_priority_mask))) else $error("mask read wrong");
  publish_hold_a: assert property (!data_sync_barrier |=> $stable(published))
    else $error("published moved without barrier");
  publish_mask_a: assert property (
    data_sync_barrier ##1 published.priority_hint_enable
    |-> published.priority_mask == $past(effective_priority_mask)) else $error("mask not published");
  fiq_swap_a: assert property (
    exception_return |=> group0_is_fiq == $past(group0_is_fiq_next)) else $error("fiq swap late");
  fiq_hold_a: assert property (!exception_return |=> $stable(group0_is_fiq))
    else $error("fiq assignment moved");
  blocked_raz_a: assert property (phys_done_s and !pwrite |-> prdata == 32'h0)
    else $error("blocked read not zero");
  blocked_flag_a: assert property (phys_done_s |-> ##[0:1] forbidden_access)
    else $error("forbidden access not flagged");
  forbidden_sticky_a: assert property (
    forbidden_access && !(sys_valid && sys_req.wr && sys_req.index == cpu_if_pkg::REG_STATUS)
    |=> forbidden_access) else $error("forbidden flag dropped");
endmodule

bind cpu_if_coherency cpu_if_coherency_asserts i_cpu_if_coherency_asserts (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .sys_req, .sys_valid,
  .sys_rdata, .sre_secure, .exception_return, .group0_is_fiq_next, .data_sync_barrier,
  .effective_priority_mask, .group0_is_fiq, .forbidden_access, .published
);

/* File: test/core_model.sv */
`timescale 1ns/1ps
module core_model (
  // Clock
  input  wire logic                clk,
  // System register view
  output cpu_if_pkg::sysreg_req_t  sys_req,
  output logic                     sys_valid,
  input  wire logic [31:0]         sys_rdata,
  // Barrier
  output logic                     data_sync_barrier
);
  initial begin
    sys_req = '0;
    sys_valid = 1'b0;
    data_sync_barrier = 1'b0;
  end
  // All shared state is reached through the system register view
  task automatic sys_acc(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk);
    sys_req <= '{wr: wr, index: idx, data: d};
    sys_valid <= 1'b1;
    @(posedge clk);
    sys_valid <= 1'b0;
    sys_req <= '{wr: 1'b0, index: ~idx, data: ~d};
    @(negedge clk);
    q = sys_rdata;
  endtask
  // Context synchronisation gap ahead of the barrier pulse
  task automatic barrier();
    @(posedge clk);
    @(posedge clk);
    data_sync_barrier <= 1'b1;
    @(posedge clk);
    data_sync_barrier <= 1'b0;
    @(negedge clk);
  endtask
endmodule

/* File: test/cpu_if_coherency_bench.sv */
`timescale 1ns/1ps
module cpu_if_coherency_bench;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, sys_rdata, q;
  logic pready, pslverr, sys_valid, data_sync_barrier, ack_sync_done, group0_is_fiq;
  logic forbidden_access, sync_seen = 1'b0;
  logic sre_secure = 1'b0, sre_hyp = 1'b0, sre_nonsecure = 1'b0, fiq_mask_bit = 1'b0;
  logic exception_return = 1'b0, group0_is_fiq_next = 1'b1;
  logic ack_valid = 1'b0, ack_is_spi = 1'b0, ack_is_virtual_locality_interrupt_direct = 1'b0;
  logic deact_valid = 1'b0, deact_is_spi = 1'b0;
  logic [23:0] ack_id = '0, deact_id = '0;
  logic [7:0] effective_priority_mask;
  cpu_if_pkg::sysreg_req_t sys_req;
  cpu_if_pkg::publish_t published;
  int failures = 0, n_checks = 0;

  always #50 clk = ~clk;
  always @(posedge clk) if (ack_sync_done === 1'b1) sync_seen <= 1'b1;

  cpu_if_coherency i_cpu_if_coherency (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sys_req, .sys_valid, .sys_rdata, .sre_secure, .sre_hyp, .sre_nonsecure,
    .secure_access(1'b1), .fiq_mask_bit, .irq_mask_bit(1'b0), .exception_return,
    .group0_is_fiq_next, .ack_valid, .ack_is_spi, .ack_is_virtual_locality_interrupt_direct, .ack_id,
    .ack_read_group1(1'b0), .deact_valid, .deact_is_spi, .deact_id, .data_sync_barrier,
    .effective_priority_mask, .ack_sync_done, .group0_is_fiq, .forbidden_access, .published
  );
  core_model i_core_model (.clk, .sys_req, .sys_valid, .sys_rdata, .data_sync_barrier);

  task automatic conclude();
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [1:0] v, input logic [7:0] i,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {v, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      conclude();
    end
  endtask
  task automatic sw(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] x;
    i_core_model.sys_acc(1'b1, i, d, x);
  endtask
  task automatic ev(input logic dct, input logic spi, input logic vl, input logic [23:0] id);
    @(posedge clk);
    ack_valid <= !dct;
    deact_valid <= dct;
    ack_is_spi <= spi;
    deact_is_spi <= spi;
    ack_is_virtual_locality_interrupt_direct <= vl;
    ack_id <= id;
    deact_id <= id;
    @(posedge clk);
    ack_valid <= 1'b0;
    deact_valid <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(32'(effective_priority_mask), 32'h0);
    check(32'(group0_is_fiq), 32'h1);
    sw(cpu_if_pkg::REG_PRIORITY_MASK, 32'h5A);
    apb(1'b0, 2'h0, cpu_if_pkg::REG_PRIORITY_MASK, 32'h0, q);
    check(q, 32'h5A);
    apb(1'b1, 2'h0, cpu_if_pkg::REG_PRIORITY_MASK, 32'h3C, q);
    i_core_model.sys_acc(1'b0, cpu_if_pkg::REG_PRIORITY_MASK, 32'h0, q);
    check(q, 32'h3C);
    check(32'(effective_priority_mask), 32'h3C);
    for (int n = 0; n < cpu_if_pkg::AP_WORDS; n++) begin
      sw(cpu_if_pkg::REG_GROUP0_AP_BASE + 8'(n), 32'hA000_0000 + n);
      apb(1'b0, 2'h0, cpu_if_pkg::REG_GROUP0_AP_BASE + 8'(n), 32'h0, q);
      check(q, 32'hA000_0000 + n);
      apb(1'b1, 2'h0, cpu_if_pkg::REG_NS_AP_BASE + 8'(n), 32'h0B00_0000 + n, q);
      i_core_model.sys_acc(1'b0, cpu_if_pkg::REG_NS_AP_BASE + 8'(n), 32'h0, q);
      check(q, 32'h0B00_0000 + n);
    end
    sw(cpu_if_pkg::REG_CONTROL, 32'h0);
    sw(cpu_if_pkg::REG_BINARY_POINT, 32'h5);
    apb(1'b0, 2'h0, cpu_if_pkg::REG_BINARY_POINT, 32'h0, q);
    check(q, 32'h5);
    sw(cpu_if_pkg::REG_BINARY_POINT, 32'h0);
    apb(1'b0, 2'h0, cpu_if_pkg::REG_BINARY_POINT, 32'h0, q);
    check(q, 32'(cpu_if_pkg::BP_G0_MIN));
    sw(cpu_if_pkg::REG_ALIAS_BP, 32'h3);
    apb(1'b0, 2'h0, cpu_if_pkg::REG_ALIAS_BP, 32'h0, q);
    check(q, 32'h3);
    apb(1'b0, 2'h0, cpu_if_pkg::REG_SGI_GENERATE, 32'h0, q);
    check(q, 32'hDEAD_BEEF);
    apb(1'b0, 2'h0, 8'h30, 32'h0, q);
    check(q, 32'h0);
    @(posedge clk);
    sre_secure <= 1'b1;
    sre_hyp <= 1'b1;
    sre_nonsecure <= 1'b1;
    apb(1'b1, 2'h0, cpu_if_pkg::REG_PRIORITY_MASK, 32'h77, q);
    for (int v = 0; v < 3; v++) begin
      apb(1'b0, 2'(v), cpu_if_pkg::REG_PRIORITY_MASK, 32'h0, q);
      check(q, 32'h0);
    end
    i_core_model.sys_acc(1'b0, cpu_if_pkg::REG_PRIORITY_MASK, 32'h0, q);
    check(q, 32'hC3);
    check(32'(forbidden_access), 32'h1);
    sw(cpu_if_pkg::REG_STATUS, 32'h0);
    check(32'(forbidden_access), 32'h0);
    @(posedge clk);
    sre_secure <= 1'b0;
    sw(cpu_if_pkg::REG_CONTROL, 32'h3E);
    sw(cpu_if_pkg::REG_PRIORITY_MASK, 32'h40);
    sw(cpu_if_pkg::REG_SGI_GENERATE, 32'h1234);
    ev(1'b0, 1'b1, 1'b0, 24'h20);
    ev(1'b0, 1'b0, 1'b0, 24'h5);
    ev(1'b0, 1'b0, 1'b1, 24'h2000);
    ev(1'b1, 1'b1, 1'b0, 24'h21);
    ev(1'b1, 1'b0, 1'b0, 24'h6);
    check(published.sgi_generate, 32'h0);
    i_core_model.barrier();
    check(32'(published.priority_mask), 32'h40);
    check(published.sgi_generate, 32'h1234);
    check(32'({published.group0_enable, published.group1_enable}), 32'h3);
    check(32'({published.vgroup0_enable, published.vgroup1_enable}), 32'h3);
    check(32'(published.spi_ack_id), 32'h20);
    check(32'(published.local_ack_id), 32'h5);
    check(32'(published.virtual_locality_interrupt_ack_id), 32'h2000);
    check(32'(published.spi_deactivate_id), 32'h21);
    check(32'(published.local_deactivate_id), 32'h6);
    sw(cpu_if_pkg::REG_CONTROL, 32'h3C);
    sw(cpu_if_pkg::REG_PRIORITY_MASK, 32'h11);
    i_core_model.barrier();
    check(32'(published.priority_mask), 32'h40);
    check(32'(effective_priority_mask), 32'h11);
    @(posedge clk);
    exception_return <= 1'b1;
    group0_is_fiq_next <= 1'b0;
    @(posedge clk);
    exception_return <= 1'b0;
    @(negedge clk);
    check(32'(group0_is_fiq), 32'h0);
    @(posedge clk);
    fiq_mask_bit <= 1'b1;
    ev(1'b0, 1'b0, 1'b0, 24'h7);
    for (int n = 0; n < 4 && sync_seen !== 1'b1; n++) @(posedge clk);
    check(32'(sync_seen), 32'h1);
    conclude();
  end
endmodule
